// File: rtl/drive_protection_monitor.sv
// Overload warnings, suppression controls and trip latch of a motor drive.
`timescale 1ns/100ps
`default_nettype none
// How it works
// [R1] Mode 00 warns at any speed; mode 01 only at constant speed.
// [R2] First warning asserts when current reaches level one; zero disables.
// [R3] Second warning asserts when current reaches level two; zero disables.
// [R4] Selector code 03 routes warning one, code 26 routes warning two.
// [R5] Suppression enabled halts acceleration while current is at 180 percent.
// [R6] Overvoltage mode 01 trims deceleration to hold bus; mode 00 is off.
// [R7] Mode 02 accelerates while bus exceeds level during deceleration.
// [R8] On 200 V class the level is held within 330 to 395 V.
// [R9] On 400 V class the level is held within 660 to 790 V.
// [R10] Suppression acceleration time is held within 0.10 to 30.00 s.
// [R11] Proportional gain 0.00 to 5.00 acts only in mode 01.
// [R12] Integral time 0.0 to 150.0 s acts only in mode 01.
// [R13] Mode 01 runs a PI loop on the bus voltage error.
// [R14] Any fault trips: output off and alarm raised.
// [R15] Key press or terminal on-then-off clears the trip and alarm.
// [R16] Power-cycle faults ignore key and terminal until reset.
// [R17] Selector code 05 routes the alarm; relay defaults to it.
// [R18] Warnings drop below level or when mode excludes present motion.
module drive_protection_monitor #(
	parameter int TICK_CYCLES = prot_pkg::PI_TICK_CYCLES  // Integral time base tick period.
) (
	input  wire logic                         clk_sys,                 // System clock.
	input  wire logic                         sys_rst,                 // Power-on reset.
	input  wire logic                         clk_en,                  // Freezes all state.
	input  wire logic [prot_pkg::CUR_W-1:0]   current_pct,             // Output current.
	input  wire logic [prot_pkg::VOLT_W-1:0]  dc_bus_volt,             // Bus voltage.
	input  wire logic                         accelerating,            // Ramp up.
	input  wire logic                         decelerating,            // Ramp down.
	input  wire logic [1:0]                   warn_mode_sel,           // Warning mode.
	input  wire logic [prot_pkg::LVL_W-1:0]   warn_level_one,          // Level one.
	input  wire logic [prot_pkg::LVL_W-1:0]   warn_level_one_set2,     // Alt level one.
	input  wire logic                         level_set2_sel,          // Use alt level.
	input  wire logic [prot_pkg::LVL_W-1:0]   warn_level_two,          // Level two.
	input  wire logic                         overcurrent_suppress_en, // Hold enable.
	input  wire logic [1:0]                   overvolt_suppress_mode,  // Bus mode.
	input  wire logic [prot_pkg::VOLT_W-1:0]  overvolt_suppress_level, // Bus limit.
	input  wire logic                         volt_class_400,          // 400 V class.
	input  wire logic [prot_pkg::RATE_W-1:0]  overvolt_accel_rate,     // Accel time.
	input  wire logic [prot_pkg::GAIN_W-1:0]  overvolt_prop_gain,      // P gain.
	input  wire logic [prot_pkg::ITIME_W-1:0] overvolt_integral_time,  // I time.
	input  wire logic                         fault_overcurrent,       // Fault input.
	input  wire logic                         fault_overvoltage,       // Fault input.
	input  wire logic                         fault_other,             // Fault input.
	input  wire logic                         fault_power_cycle,       // Locking fault.
	input  wire logic                         reset_key,               // Stop/reset key.
	input  wire logic                         reset_terminal,          // Reset terminal.
	input  wire logic [prot_pkg::SEL_W-1:0]   output_terminal_sel_a,   // Terminal A code.
	input  wire logic [prot_pkg::SEL_W-1:0]   output_terminal_sel_b,   // Terminal B code.
	input  wire logic [prot_pkg::SEL_W-1:0]   relay_output_sel,        // Relay code.
	output logic                              overload_warning_out,    // Warning one.
	output logic                              overload_warning2_out,   // Warning two.
	output logic                              accel_hold_out,          // Halt ramp up.
	output logic                              ov_accel_out,            // Accelerate now.
	output logic [prot_pkg::RATE_W-1:0]       ov_accel_rate_out,       // Used accel time.
	output logic signed [prot_pkg::TRIM_W-1:0] ov_decel_trim_out,      // PI output.
	output logic                              output_off_out,          // Output shut off.
	output logic                              alarm_out,               // Trip alarm.
	output logic                              term_a_out,              // Terminal A.
	output logic                              term_b_out,              // Terminal B.
	output logic                              relay_out                // Relay.
);
	import prot_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                        warn1;
		logic                        warn2;
		logic                        oc_hold;
		logic                        ov_accel;
		logic                        out_off;
		logic                        alarm;
		trip_state_t                 trip;
		logic                        term_d;
		logic [VOLT_W-1:0]           ov_lvl;
		logic [RATE_W-1:0]           rate;
		logic signed [INTEG_W-1:0]   integ;
		logic signed [TRIM_W-1:0]    trim;
		logic [TICK_W-1:0]           tick_cnt;
		logic [ITIME_W-1:0]          ti_cnt;
	} state_t;

	state_t cur;
	state_t nxt;

	logic [LVL_W-1:0]          lvl1;
	logic [LVL_W-1:0]          lvl2;
	logic                      eval_ok;
	logic                      any_fault;
	logic                      clear_req;
	logic [GAIN_W-1:0]         gain;
	logic [ITIME_W-1:0]        itime;
	logic signed [11:0]        err;
	logic signed [INTEG_W:0]   isum;
	logic signed [INTEG_W:0]   psum;
	logic                      pi_run;
	logic                      tick;

	// ------------------------------------------------------------
	// Setting clamps
	// ------------------------------------------------------------
	// Out-of-range settings are pinned to the nearest bound so a bad write
	// can never push the block into an unintended operating point.
	always_comb begin
		lvl1 = level_set2_sel ? warn_level_one_set2 : warn_level_one;
		if (lvl1 > LEVEL_MAX) begin
			lvl1 = LEVEL_MAX;
		end
		lvl2 = (warn_level_two > LEVEL_MAX) ? LEVEL_MAX : warn_level_two;
		gain = (overvolt_prop_gain > GAIN_MAX) ? GAIN_MAX : overvolt_prop_gain;
		itime = (overvolt_integral_time > ITIME_MAX) ? ITIME_MAX
			: overvolt_integral_time;
	end

	// Warnings only count in the motion states the mode allows.
	assign eval_ok = (warn_mode_sel == WARN_MODE_ALL)
		|| (!accelerating && !decelerating);  // R1

	assign any_fault = fault_overcurrent | fault_overvoltage
		| fault_other | fault_power_cycle;

	// The terminal requests a reset on its release, not on its press.
	assign clear_req = reset_key || (cur.term_d && !reset_terminal);  // R15

	// Bus error against the held suppression level.
	assign err  = $signed({2'h0, dc_bus_volt}) - $signed({2'h0, cur.ov_lvl});
	assign isum = $signed({cur.integ[INTEG_W-1], cur.integ})
		+ $signed({{(INTEG_W-11){err[11]}}, err});
	assign psum = isum;
	assign pi_run = (overvolt_suppress_mode == OV_MODE_PI) && decelerating
		&& (cur.trip == TRIP_CLEAR);
	assign tick = (cur.tick_cnt == TICK_W'(TICK_CYCLES - 1));

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		nxt = cur;
		nxt.term_d = reset_terminal;

		// Overload warnings.
		nxt.warn1 = eval_ok && (lvl1 != '0)
			&& (current_pct >= {1'b0, lvl1});  // R2 R18
		nxt.warn2 = eval_ok && (lvl2 != '0)
			&& (current_pct >= {1'b0, lvl2});  // R3 R18

		// Acceleration halt near the overcurrent limit.
		nxt.oc_hold = overcurrent_suppress_en && accelerating
			&& (current_pct >= OC_LIMIT_PCT)
			&& (cur.trip == TRIP_CLEAR);  // R5

		// Suppression level held inside the class range.
		if (volt_class_400) begin
			if (overvolt_suppress_level < OV_LVL_400_MIN) begin
				nxt.ov_lvl = OV_LVL_400_MIN;  // R9
			end else if (overvolt_suppress_level > OV_LVL_400_MAX) begin
				nxt.ov_lvl = OV_LVL_400_MAX;  // R9
			end else begin
				nxt.ov_lvl = overvolt_suppress_level;
			end
		end else begin
			if (overvolt_suppress_level < OV_LVL_200_MIN) begin
				nxt.ov_lvl = OV_LVL_200_MIN;  // R8
			end else if (overvolt_suppress_level > OV_LVL_200_MAX) begin
				nxt.ov_lvl = OV_LVL_200_MAX;  // R8
			end else begin
				nxt.ov_lvl = overvolt_suppress_level;
			end
		end

		// Acceleration time used while the bus is above the level.
		if (overvolt_accel_rate < RATE_MIN) begin
			nxt.rate = RATE_MIN;  // R10
		end else if (overvolt_accel_rate > RATE_MAX) begin
			nxt.rate = RATE_MAX;  // R10
		end else begin
			nxt.rate = overvolt_accel_rate;
		end

		// Mode 02: accelerate above the level, resume deceleration below.
		// At exactly the level the previous decision is kept.
		if ((overvolt_suppress_mode != OV_MODE_ACCEL) || !decelerating
			|| (cur.trip != TRIP_CLEAR)) begin
			nxt.ov_accel = 1'b0;  // R6
		end else if (dc_bus_volt > cur.ov_lvl) begin
			nxt.ov_accel = 1'b1;  // R7
		end else if (dc_bus_volt < cur.ov_lvl) begin
			nxt.ov_accel = 1'b0;  // R7
		end

		// Mode 01: PI loop. The integrator steps once per integral time,
		// which keeps the datapath free of a divider; a zero time turns
		// the integral path off.
		nxt.tick_cnt = tick ? '0 : cur.tick_cnt + TICK_W'(1);
		if (!pi_run) begin
			nxt.integ  = '0;  // R12
			nxt.ti_cnt = '0;
			nxt.trim   = '0;  // R6 R11
		end else begin
			if (tick && (itime != '0)) begin
				if (cur.ti_cnt + ITIME_W'(1) >= itime) begin
					nxt.ti_cnt = '0;
					if (isum[INTEG_W] != isum[INTEG_W-1]) begin
						nxt.integ = isum[INTEG_W] ? {1'b1, {(INTEG_W-1){1'b0}}}
							: {1'b0, {(INTEG_W-1){1'b1}}};
					end else begin
						nxt.integ = isum[INTEG_W-1:0];  // R12 R13
					end
				end else begin
					nxt.ti_cnt = cur.ti_cnt + ITIME_W'(1);
				end
			end
			nxt.trim = TRIM_W'($signed({1'b0, gain})) * TRIM_W'(psum);  // R11 R13
		end

		// Trip latch. A fault in the same cycle as a clear request wins.
		case (cur.trip)
			TRIP_CLEAR: begin
				if (fault_power_cycle) begin
					nxt.trip = TRIP_LOCKED;  // R16
				end else if (any_fault) begin
					nxt.trip = TRIP_LATCHED;  // R14
				end
			end
			TRIP_LATCHED: begin
				if (fault_power_cycle) begin
					nxt.trip = TRIP_LOCKED;  // R16
				end else if (clear_req && !any_fault) begin
					nxt.trip = TRIP_CLEAR;  // R15
				end
			end
			TRIP_LOCKED: begin
				nxt.trip = TRIP_LOCKED;  // R16
			end
			default: begin
				nxt.trip = TRIP_LATCHED;
			end
		endcase
		nxt.out_off = (nxt.trip != TRIP_CLEAR);  // R14
		nxt.alarm   = (nxt.trip != TRIP_CLEAR);  // R14 R15
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset stands in for a power cycle and is the only way out of a lock.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur        <= '0;
			cur.trip   <= TRIP_CLEAR;
			cur.ov_lvl <= OV_LVL_200_DEF;
			cur.rate   <= RATE_DEF;
		end else if (clk_en) begin
			cur <= nxt;
		end
	end

	assign overload_warning_out  = cur.warn1;
	assign overload_warning2_out = cur.warn2;
	assign accel_hold_out        = cur.oc_hold;
	assign ov_accel_out          = cur.ov_accel;
	assign ov_accel_rate_out     = cur.rate;
	assign ov_decel_trim_out     = cur.trim;
	assign output_off_out        = cur.out_off;
	assign alarm_out             = cur.alarm;

	// ------------------------------------------------------------
	// Assignable outputs
	// ------------------------------------------------------------
	// Each output adds one register stage after the signal it carries.
	output_router u_route_a (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.func_sel  (output_terminal_sel_a),
		.warn1     (cur.warn1),
		.warn2     (cur.warn2),
		.alarm     (cur.alarm),
		.route_out (term_a_out)
	);

	output_router u_route_b (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.func_sel  (output_terminal_sel_b),
		.warn1     (cur.warn1),
		.warn2     (cur.warn2),
		.alarm     (cur.alarm),
		.route_out (term_b_out)
	);

	output_router u_route_relay (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.func_sel  (relay_output_sel),
		.warn1     (cur.warn1),
		.warn2     (cur.warn2),
		.alarm     (cur.alarm),
		.route_out (relay_out)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking dflt_cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	warn_mode_a: assert property ( // R1
		clk_en && warn_mode_sel == WARN_MODE_CONST && accelerating
		|=> !overload_warning_out && !overload_warning2_out)
		else $error("Warning raised outside constant speed.");

	warn_one_a: assert property ( // R2
		clk_en && eval_ok && lvl1 != '0 && current_pct >= {1'b0, lvl1}
		|=> overload_warning_out)
		else $error("First warning missed at level.");

	warn_two_a: assert property ( // R3
		clk_en && eval_ok && lvl2 != '0 && current_pct >= {1'b0, lvl2}
		|=> overload_warning2_out)
		else $error("Second warning missed at level.");

	warn_drop_a: assert property ( // R18
		clk_en && current_pct < {1'b0, lvl1} |=> !overload_warning_out)
		else $error("First warning held below level.");

	oc_hold_a: assert property ( // R5
		clk_en && overcurrent_suppress_en && accelerating
		&& current_pct >= OC_LIMIT_PCT && cur.trip == TRIP_CLEAR
		|=> accel_hold_out)
		else $error("Acceleration not halted at current limit.");

	ov_off_a: assert property ( // R6
		clk_en && overvolt_suppress_mode == OV_MODE_OFF
		|=> ov_decel_trim_out == '0 && !ov_accel_out)
		else $error("Suppression active while disabled.");

	ov_accel_a: assert property ( // R7
		clk_en && overvolt_suppress_mode == OV_MODE_ACCEL && decelerating
		&& cur.trip == TRIP_CLEAR && dc_bus_volt > cur.ov_lvl
		|=> ov_accel_out)
		else $error("No acceleration above bus level.");

	ov_level_a: assert property ( // R8
		clk_en && !volt_class_400
		|=> cur.ov_lvl >= OV_LVL_200_MIN && cur.ov_lvl <= OV_LVL_200_MAX)
		else $error("Bus level outside 200 V range.");

	rate_range_a: assert property ( // R10
		clk_en |=> ov_accel_rate_out >= RATE_MIN && ov_accel_rate_out <= RATE_MAX)
		else $error("Acceleration time outside range.");

	trip_set_a: assert property ( // R14
		clk_en && any_fault |=> alarm_out && output_off_out)
		else $error("Fault did not trip.");

	trip_clear_a: assert property ( // R15
		clk_en && cur.trip == TRIP_LATCHED && reset_key && !any_fault
		|=> !alarm_out ##0 !output_off_out)
		else $error("Key did not clear trip.");

	trip_lock_a: assert property ( // R16
		clk_en && cur.trip == TRIP_LOCKED |=> alarm_out && cur.trip == TRIP_LOCKED)
		else $error("Locked trip was released.");

endmodule : drive_protection_monitor
`default_nettype wire

// File: rtl/output_router.sv
// One assignable output: picks a signal by function code and registers it.
`timescale 1ns/100ps
`default_nettype none
module output_router (
	input  wire logic                       clk_sys,   // System clock.
	input  wire logic                       sys_rst,   // Synchronous reset.
	input  wire logic                       clk_en,    // Freezes state when low.
	input  wire logic [prot_pkg::SEL_W-1:0] func_sel,  // Function code.
	input  wire logic                       warn1,     // First overload warning.
	input  wire logic                       warn2,     // Second overload warning.
	input  wire logic                       alarm,     // Trip alarm.
	output logic                            route_out  // Registered output level.
);
	import prot_pkg::*;

	typedef struct packed {
		logic route;
	} route_state_t;

	route_state_t cur;
	route_state_t nxt;

	// Unknown codes drive the output low.
	always_comb begin
		nxt = cur;
		case (func_sel)
			SEL_OVERLOAD:  nxt.route = warn1;  // R4
			SEL_OVERLOAD2: nxt.route = warn2;  // R4
			SEL_ALARM:     nxt.route = alarm;  // R17
			default:       nxt.route = 1'b0;
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur <= '0;
		end else if (clk_en) begin
			cur <= nxt;
		end
	end

	assign route_out = cur.route;

	route_alarm_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R17
		clk_en && func_sel == SEL_ALARM |=> route_out == $past(alarm))
		else $error("Alarm not routed by code 05.");

endmodule : output_router
`default_nettype wire

// File: rtl/prot_pkg.sv
// Shared constants and types for the drive protection monitor.
package prot_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PI_TICK_MS     = 100;
	localparam int PI_TICK_CYCLES = PI_TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICK_W         = 24;

	// ------------------------------------------------------------
	// Field widths
	// ------------------------------------------------------------
	localparam int CUR_W   = 9;   // Current in percent of rated.
	localparam int LVL_W   = 8;   // Warning level in percent of rated.
	localparam int SEL_W   = 8;   // Output function selector code.
	localparam int VOLT_W  = 10;  // DC bus voltage in volts.
	localparam int RATE_W  = 12;  // Acceleration time in 0.01 s.
	localparam int GAIN_W  = 9;   // Proportional gain in 0.01.
	localparam int ITIME_W = 11;  // Integral time in 0.1 s.
	localparam int INTEG_W = 20;
	localparam int TRIM_W  = 31;

	// ------------------------------------------------------------
	// Overload warning
	// ------------------------------------------------------------
	localparam logic [1:0]       WARN_MODE_ALL   = 2'h0;
	localparam logic [1:0]       WARN_MODE_CONST = 2'h1;
	localparam logic [LVL_W-1:0] LEVEL_MAX       = 8'hC8;
	localparam logic [LVL_W-1:0] LEVEL_DEFAULT   = 8'h73;

	// ------------------------------------------------------------
	// Overcurrent and overvoltage suppression
	// ------------------------------------------------------------
	localparam logic [CUR_W-1:0]   OC_LIMIT_PCT   = 9'h0B4;
	localparam logic               OC_EN_DEFAULT  = 1'h0;
	localparam logic [1:0]         OV_MODE_OFF    = 2'h0;
	localparam logic [1:0]         OV_MODE_PI     = 2'h1;
	localparam logic [1:0]         OV_MODE_ACCEL  = 2'h2;
	localparam logic [VOLT_W-1:0]  OV_LVL_200_MIN = 10'h14A;
	localparam logic [VOLT_W-1:0]  OV_LVL_200_MAX = 10'h18B;
	localparam logic [VOLT_W-1:0]  OV_LVL_200_DEF = 10'h17C;
	localparam logic [VOLT_W-1:0]  OV_LVL_400_MIN = 10'h294;
	localparam logic [VOLT_W-1:0]  OV_LVL_400_MAX = 10'h316;
	localparam logic [VOLT_W-1:0]  OV_LVL_400_DEF = 10'h2F8;
	localparam logic [RATE_W-1:0]  RATE_MIN       = 12'h00A;
	localparam logic [RATE_W-1:0]  RATE_MAX       = 12'hBB8;
	localparam logic [RATE_W-1:0]  RATE_DEF       = 12'h064;
	localparam logic [GAIN_W-1:0]  GAIN_MAX       = 9'h1F4;
	localparam logic [GAIN_W-1:0]  GAIN_DEF       = 9'h014;
	localparam logic [ITIME_W-1:0] ITIME_MAX      = 11'h5DC;
	localparam logic [ITIME_W-1:0] ITIME_DEF      = 11'h00A;

	// ------------------------------------------------------------
	// Output function selector codes
	// ------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_OVERLOAD   = 8'h03;
	localparam logic [SEL_W-1:0] SEL_ALARM      = 8'h05;
	localparam logic [SEL_W-1:0] SEL_OVERLOAD2  = 8'h1A;
	localparam logic [SEL_W-1:0] RELAY_SEL_DEF  = 8'h05;

	// ------------------------------------------------------------
	// Trip state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TRIP_CLEAR   = 3'b001,
		TRIP_LATCHED = 3'b010,
		TRIP_LOCKED  = 3'b100
	} trip_state_t;

endpackage : prot_pkg

// File: testbench/ctrl_partner.sv
// External controller model that drives the reset terminal of the monitor.
`timescale 1ns/100ps
`default_nettype none
module ctrl_partner (
	input  wire logic clk_sys,        // System clock.
	input  wire logic pulse_req,      // Bench asks for one reset pulse.
	output logic      reset_terminal  // Reset terminal drive.
);
	// The request is taken on the rising edge so the bench, which writes it on the
	// falling edge, never races with this model on one edge.
	logic req_seen = 1'b0;
	initial reset_terminal = 1'b0;
	always @(posedge clk_sys) begin
		req_seen <= pulse_req;
	end
	// The terminal goes on for one cycle and then off, away from the sampling edge.
	always @(negedge clk_sys) begin
		reset_terminal <= req_seen;
	end
endmodule : ctrl_partner
`default_nettype wire

// File: testbench/drive_protection_monitor_bench.sv
// Self-checking bench for the drive protection monitor.
`timescale 1ns/100ps
`default_nettype none
module drive_protection_monitor_bench;
	import prot_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, accelerating = 1'b0;
	logic decelerating = 1'b0, level_set2_sel = 1'b0, overcurrent_suppress_en = 1'b0;
	logic volt_class_400 = 1'b0, fault_overcurrent = 1'b0, fault_overvoltage = 1'b0;
	logic fault_other = 1'b0, fault_power_cycle = 1'b0, reset_key = 1'b0, pulse_req = 1'b0;
	logic [CUR_W-1:0] current_pct = 9'h000;
	logic [VOLT_W-1:0] dc_bus_volt = 10'h000, overvolt_suppress_level = 10'h000;
	logic [1:0] warn_mode_sel = 2'h0, overvolt_suppress_mode = 2'h0;
	logic [LVL_W-1:0] warn_level_one = 8'h00, warn_level_one_set2 = 8'h00, warn_level_two = 8'h00;
	logic [RATE_W-1:0] overvolt_accel_rate = 12'h064;
	logic [GAIN_W-1:0] overvolt_prop_gain = 9'h000;
	logic [ITIME_W-1:0] overvolt_integral_time = 11'h000;
	logic [SEL_W-1:0] output_terminal_sel_a = SEL_OVERLOAD, output_terminal_sel_b = SEL_OVERLOAD2;
	logic [SEL_W-1:0] relay_output_sel = SEL_ALARM;
	wire logic reset_terminal, overload_warning_out, overload_warning2_out, accel_hold_out;
	wire logic ov_accel_out, output_off_out, alarm_out, term_a_out, term_b_out, relay_out;
	wire logic [RATE_W-1:0] ov_accel_rate_out;
	wire logic signed [TRIM_W-1:0] ov_decel_trim_out;
	int err_total = 0, check_count = 0, cyc = 0;

	// Short integral time base tick keeps the integral test within a few dozen cycles.
	drive_protection_monitor #(.TICK_CYCLES(4)) u_drive_protection_monitor (.clk_sys, .sys_rst,
		.clk_en, .current_pct, .dc_bus_volt, .accelerating, .decelerating, .warn_mode_sel,
		.warn_level_one, .warn_level_one_set2, .level_set2_sel, .warn_level_two,
		.overcurrent_suppress_en, .overvolt_suppress_mode, .overvolt_suppress_level,
		.volt_class_400, .overvolt_accel_rate, .overvolt_prop_gain, .overvolt_integral_time,
		.fault_overcurrent, .fault_overvoltage, .fault_other, .fault_power_cycle, .reset_key,
		.reset_terminal, .output_terminal_sel_a, .output_terminal_sel_b, .relay_output_sel,
		.overload_warning_out, .overload_warning2_out, .accel_hold_out, .ov_accel_out,
		.ov_accel_rate_out, .ov_decel_trim_out, .output_off_out, .alarm_out, .term_a_out,
		.term_b_out, .relay_out);
	ctrl_partner u_ctrl_partner (.clk_sys, .pulse_req, .reset_terminal);

	// Free-running clock; a hang is cut short well past the planned run length.
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			test_done();
		end
	end

	// Inputs change on the falling edge, so outputs are read settled there too.
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : step

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// Main sequence: warnings, suppression, trip and clear.
	initial begin
		step(12);
		sys_rst = 1'b0;
		accelerating = 1'b1; warn_level_one = 8'h64; current_pct = 9'h064; step(4);
		chk("warn1_any", 1, overload_warning_out);
		chk("term_a", 1, term_a_out);
		warn_mode_sel = WARN_MODE_CONST; step(4);
		chk("warn1_accel", 0, overload_warning_out);
		accelerating = 1'b0; current_pct = 9'h063; step(4);
		chk("warn1_below", 0, overload_warning_out);
		warn_level_one = 8'hFF; current_pct = 9'h0C8; step(4);
		chk("warn1_clamp", 1, overload_warning_out);
		warn_level_one = 8'h00; step(4);
		chk("warn1_off", 0, overload_warning_out);
		level_set2_sel = 1'b1; warn_level_one_set2 = 8'h32; warn_level_two = 8'hC8; step(4);
		chk("warn1_alt", 1, overload_warning_out);
		chk("warn2", 1, overload_warning2_out);
		chk("term_b", 1, term_b_out);
		output_terminal_sel_a = 8'h00; step(2);
		chk("term_a_none", 0, term_a_out);
		current_pct = 9'h0C7; step(4);
		chk("warn2_below", 0, overload_warning2_out);
		accelerating = 1'b1; overcurrent_suppress_en = 1'b1; current_pct = OC_LIMIT_PCT; step(4);
		chk("hold", 1, accel_hold_out);
		current_pct = OC_LIMIT_PCT - 9'h001; step(4);
		chk("hold_below", 0, accel_hold_out);
		accelerating = 1'b0; decelerating = 1'b1; overvolt_suppress_mode = OV_MODE_ACCEL;
		overvolt_suppress_level = 10'h12C; dc_bus_volt = OV_LVL_200_MIN + 10'h001;
		overvolt_accel_rate = 12'h005; step(4);
		chk("ov_accel", 1, ov_accel_out);
		chk("rate_min", RATE_MIN, ov_accel_rate_out);
		dc_bus_volt = OV_LVL_200_MIN - 10'h001; overvolt_accel_rate = 12'hFFF; step(4);
		chk("ov_resume", 0, ov_accel_out);
		chk("rate_max", RATE_MAX, ov_accel_rate_out);
		volt_class_400 = 1'b1; overvolt_suppress_level = 10'h3FF; dc_bus_volt = OV_LVL_400_MAX + 10'h001;
		step(4);
		chk("ov_400", 1, ov_accel_out);
		overvolt_suppress_mode = OV_MODE_OFF; step(4);
		chk("ov_off", 0, ov_accel_out);
		volt_class_400 = 1'b0; overvolt_suppress_level = OV_LVL_200_DEF; overvolt_prop_gain = GAIN_DEF;
		overvolt_suppress_mode = OV_MODE_PI; dc_bus_volt = OV_LVL_200_DEF + 10'h00A; step(4);
		chk("trim_p", 200, ov_decel_trim_out);
		overvolt_integral_time = ITIME_DEF; step(60);
		chk("trim_i", 400, ov_decel_trim_out);
		overvolt_suppress_mode = OV_MODE_ACCEL; step(4);
		chk("trim_mode2", 0, ov_decel_trim_out);
		decelerating = 1'b0; fault_other = 1'b1; reset_key = 1'b1; step(2);
		chk("alarm", 1, alarm_out);
		chk("off", 1, output_off_out);
		chk("relay", 1, relay_out);
		fault_other = 1'b0; step(3);
		chk("key_clear", 0, alarm_out);
		reset_key = 1'b0; fault_overcurrent = 1'b1; step(1);
		fault_overcurrent = 1'b0; pulse_req = 1'b1; step(1);
		pulse_req = 1'b0; step(1);
		chk("term_hold", 1, alarm_out);
		step(3);
		chk("term_clear", 0, alarm_out);
		fault_power_cycle = 1'b1; step(1);
		fault_power_cycle = 1'b0; reset_key = 1'b1; pulse_req = 1'b1; step(1);
		reset_key = 1'b0; pulse_req = 1'b0; step(4);
		chk("locked", 1, alarm_out);
		sys_rst = 1'b1; step(1);
		sys_rst = 1'b0; step(2);
		chk("power_clear", 0, alarm_out);
		test_done();
	end
endmodule : drive_protection_monitor_bench
`default_nettype wire
